// [src/crt_raster_timing_controller.v]
// Raster scan video timing controller with processor register port and light pen capture
//
// Function
// - Processor access only while select low
// - Register select low: write index, read status
// - Register select high: access indexed internal register
// - Direction high reads, low writes
// - Data lines driven only during selected reads
// - Transfers timed by stoppable bus phase clock
// - Programmed line sync pulse, active high
// - Programmed frame sync pulse, active high
// - Active video inside displayed columns and rows
// - Mode bit 4 delays active video
// - Caret on address match within line bounds
// - Mode bit 5 delays caret output
// - Pen rising edge captures refresh address
// - Character clock times all scan logic
// - Scan reset low clears outputs, all counters but field
// - Scan restarts from initial state on release
// - Fourteen refresh address outputs from start
// - Mode bit 2 clear: linear addresses
// - Mode bit 2 set: row/column addresses
// - Sixteen K characters, 32 lines per row
// - Five-bit write-only index, registers 0-17
// - Pen capture on next character falling edge
// - Caret start bits 6:5 select blink mode
// - Five raster line outputs give scan line
`timescale 1ns/1ps
`include "crt_regs.vh"
module crt_raster_timing_controller #(
	parameter ADDR_W = 14,
	parameter LINE_W = 5
) (
	input  wire              clock,
	input  wire              rst,
	input  wire              bus_phase,
	input  wire              select_n,
	input  wire              register_select,
	input  wire              read_write,
	input  wire [7:0]        data_in,
	output reg  [7:0]        data_out,
	output reg               data_oe,
	input  wire              char_clock,
	input  wire              pen_strobe,
	input  wire              scan_reset_n,
	output reg               hsync,
	output reg               vsync,
	output reg               display_enable,
	output reg               cursor,
	output reg  [ADDR_W-1:0] refresh_addr,
	output reg  [LINE_W-1:0] raster_line
);
	wire        phase_s;
	wire        sel_n_s;
	wire        rs_s;
	wire        rw_s;
	wire        cc_s;
	wire        pen_s;
	wire        sres_n_s;
	wire [7:0]  din_s;

	// All pins cross into the system clock domain first
	crt_sync #(.WIDTH(15)) u_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in ({bus_phase, select_n, register_select, read_write, char_clock, pen_strobe, scan_reset_n, data_in}),
		.sync_out ({phase_s, sel_n_s, rs_s, rw_s, cc_s, pen_s, sres_n_s, din_s})
	);

	// Control registers
	reg [4:0]        index;
	reg [7:0]        htotal;
	reg [7:0]        hdisp;
	reg [7:0]        hsync_pos;
	reg [7:0]        sync_width;
	reg [6:0]        vtotal;
	reg [4:0]        vadjust;
	reg [6:0]        vdisp;
	reg [6:0]        vsync_pos;
	reg [7:0]        mode_control_reg;
	reg [4:0]        row_lines;
	reg [6:0]        caret_start_reg;
	reg [4:0]        caret_end_reg;
	reg [13:0]       start_addr;
	reg [13:0]       caret_addr;
	reg [13:0]       pen_position_reg;
	reg              pen_full;
	reg              phase_prev;
	reg [7:0]        wr_data;
	reg              cyc_sel;
	reg              cyc_rs;
	reg              cyc_rw;
	reg              cc_prev;
	reg              pen_prev;
	reg              pen_pending;
	reg [7:0]        hcount;
	reg [LINE_W-1:0] raster;
	reg [6:0]        row;
	reg              adjusting;
	reg [13:0]       row_base;
	reg [4:0]        hs_cnt;
	reg [4:0]        vs_cnt;
	reg [4:0]        field;
	reg              de_d1;
	reg              cur_d1;

	wire phase_fall = phase_prev & ~phase_s;
	wire cc_rise    = cc_s & ~cc_prev;
	wire cc_fall    = ~cc_s & cc_prev;
	wire pen_rise   = pen_s & ~pen_prev;
	wire do_write   = phase_fall & cyc_sel & ~cyc_rw;
	wire do_read    = phase_fall & cyc_sel & cyc_rw;
	wire vblank     = (row >= vdisp) | adjusting;

	// Read mux; write-only registers read as zero
	reg [7:0] rd_mux;
	always @* begin
		rd_mux = 8'h00;
		if (!rs_s) begin
			rd_mux[`CRT_STAT_PEN_FULL] = pen_full;
			rd_mux[`CRT_STAT_VBLANK]   = vblank;
		end else begin
			case (index)
				`CRT_IDX_CARET_HI: rd_mux = {2'h0, caret_addr[13:8]};
				`CRT_IDX_CARET_LO: rd_mux = caret_addr[7:0];
				`CRT_IDX_PEN_HI:   rd_mux = {2'h0, pen_position_reg[13:8]};
				`CRT_IDX_PEN_LO:   rd_mux = pen_position_reg[7:0];
				default:           rd_mux = 8'h00;
			endcase
		end
	end

	// Processor port: sample during phase high, commit at its falling edge
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_prev <= 1'b0;
			wr_data    <= `CRT_RESET_BYTE;
			cyc_sel    <= 1'b0;
			cyc_rs     <= 1'b0;
			cyc_rw     <= 1'b1;
			data_out   <= `CRT_RESET_BYTE;
			data_oe    <= 1'b0;
		end else begin
			phase_prev <= phase_s;
			if (phase_s) begin
				wr_data <= din_s;
				cyc_sel <= ~sel_n_s;
				cyc_rs  <= rs_s;
				cyc_rw  <= rw_s;
			end
			data_oe  <= phase_s & ~sel_n_s & rw_s;
			data_out <= rd_mux;
		end
	end

	// Register writes and pen flag
	wire pen_read = do_read & cyc_rs & ((index == `CRT_IDX_PEN_HI) | (index == `CRT_IDX_PEN_LO));
	wire pen_take = cc_fall & pen_pending;
	// Refresh address in the selected format
	wire [13:0] lin_addr = row_base + {6'h00, hcount};
	wire [5:0]  rc_row   = start_addr[13:8] + row[5:0];
	wire [7:0]  rc_col   = start_addr[7:0] + hcount;
	wire [13:0] ma_now   = mode_control_reg[`CRT_MODE_ROWCOL] ? {rc_row, rc_col} : lin_addr;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			index            <= 5'h00;
			htotal           <= `CRT_RESET_BYTE;
			hdisp            <= `CRT_RESET_BYTE;
			hsync_pos        <= `CRT_RESET_BYTE;
			sync_width       <= `CRT_RESET_BYTE;
			vtotal           <= 7'h00;
			vadjust          <= 5'h00;
			vdisp            <= 7'h00;
			vsync_pos        <= 7'h00;
			mode_control_reg <= `CRT_RESET_BYTE;
			row_lines        <= 5'h00;
			caret_start_reg  <= 7'h00;
			caret_end_reg    <= 5'h00;
			start_addr       <= `CRT_RESET_ADDR;
			caret_addr       <= `CRT_RESET_ADDR;
			pen_position_reg <= `CRT_RESET_ADDR;
			pen_full         <= 1'b0;
		end else begin
			if (do_write && !cyc_rs) begin
				index <= wr_data[4:0];
			end
			if (do_write && cyc_rs) begin
				case (index)
					`CRT_IDX_HTOTAL:      htotal           <= wr_data;
					`CRT_IDX_HDISP:       hdisp            <= wr_data;
					`CRT_IDX_HSYNC_POS:   hsync_pos        <= wr_data;
					`CRT_IDX_SYNC_WIDTH:  sync_width       <= wr_data;
					`CRT_IDX_VTOTAL:      vtotal           <= wr_data[6:0];
					`CRT_IDX_VADJUST:     vadjust          <= wr_data[4:0];
					`CRT_IDX_VDISP:       vdisp            <= wr_data[6:0];
					`CRT_IDX_VSYNC_POS:   vsync_pos        <= wr_data[6:0];
					`CRT_IDX_MODE:        mode_control_reg <= wr_data;
					`CRT_IDX_ROW_LINES:   row_lines        <= wr_data[4:0];
					`CRT_IDX_CARET_START: caret_start_reg  <= wr_data[6:0];
					`CRT_IDX_CARET_END:   caret_end_reg    <= wr_data[4:0];
					`CRT_IDX_START_HI:    start_addr[13:8] <= wr_data[5:0];
					`CRT_IDX_START_LO:    start_addr[7:0]  <= wr_data;
					`CRT_IDX_CARET_HI:    caret_addr[13:8] <= wr_data[5:0];
					`CRT_IDX_CARET_LO:    caret_addr[7:0]  <= wr_data;
					default:              index            <= index;
				endcase
			end
			// Capture wins over a clear by read in the same cycle
			if (pen_take) begin
				pen_position_reg <= ma_now;
				pen_full         <= 1'b1;
			end else if (pen_read) begin
				pen_full <= 1'b0;
			end
		end
	end

	// Active video and caret
	wire disp_now = (hcount < hdisp) & (row < vdisp) & ~adjusting;
	wire [1:0] caret_mode = caret_start_reg[`CRT_CARET_MODE_HI:`CRT_CARET_MODE_LO];
	reg  blink_on;
	always @* begin
		case (caret_mode)
			`CRT_CARET_STEADY:  blink_on = 1'b1;
			`CRT_CARET_OFF:     blink_on = 1'b0;
			`CRT_CARET_BLINK16: blink_on = field[`CRT_BLINK16_BIT];
			`CRT_CARET_BLINK32: blink_on = field[`CRT_BLINK32_BIT];
			default:            blink_on = 1'b0;
		endcase
	end
	wire cur_now = disp_now & blink_on & (ma_now == caret_addr)
		& (raster >= caret_start_reg[4:0]) & (raster <= caret_end_reg);

	wire hend      = (hcount == htotal);
	wire row_end   = ~adjusting & (raster == row_lines);
	wire last_row  = (row == vtotal);
	wire adj_end   = adjusting & ((raster + 5'h01) == vadjust);
	wire frame_end = hend & (adj_end | (row_end & last_row & (vadjust == 5'h00)));
	wire [4:0] hs_w = (sync_width[3:0] == 4'h0) ? `CRT_SYNC_WIDTH_ZERO : {1'b0, sync_width[3:0]};
	wire [4:0] vs_w = (sync_width[7:4] == 4'h0) ? `CRT_SYNC_WIDTH_ZERO : {1'b0, sync_width[7:4]};
	reg [4:0] next_hs_cnt;
	reg [4:0] next_vs_cnt;
	always @* begin
		next_hs_cnt = hs_cnt;
		next_vs_cnt = vs_cnt;
		if (hcount == hsync_pos) begin
			next_hs_cnt = hs_w;
		end else if (hs_cnt != 5'h00) begin
			next_hs_cnt = hs_cnt - 5'h01;
		end
		if ((hcount == 8'h00) && (raster == {LINE_W{1'b0}}) && (row == vsync_pos) && !adjusting) begin
			next_vs_cnt = vs_w;
		end else if ((hcount == 8'h00) && (vs_cnt != 5'h00)) begin
			next_vs_cnt = vs_cnt - 5'h01;
		end
	end

	// Scan logic steps on character clock rising edges only
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cc_prev        <= 1'b0;
			pen_prev       <= 1'b0;
			pen_pending    <= 1'b0;
			hcount         <= 8'h00;
			raster         <= {LINE_W{1'b0}};
			row            <= 7'h00;
			adjusting      <= 1'b0;
			row_base       <= `CRT_RESET_ADDR;
			hs_cnt         <= 5'h00;
			vs_cnt         <= 5'h00;
			field          <= 5'h00;
			de_d1          <= 1'b0;
			cur_d1         <= 1'b0;
			hsync          <= 1'b0;
			vsync          <= 1'b0;
			display_enable <= 1'b0;
			cursor         <= 1'b0;
			refresh_addr   <= {ADDR_W{1'b0}};
			raster_line    <= {LINE_W{1'b0}};
		end else begin
			cc_prev  <= cc_s;
			pen_prev <= pen_s;
			pen_pending <= pen_rise | (pen_pending & ~pen_take);
			if (!sres_n_s) begin
				hcount         <= 8'h00;
				raster         <= {LINE_W{1'b0}};
				row            <= 7'h00;
				adjusting      <= 1'b0;
				row_base       <= start_addr;
				hs_cnt         <= 5'h00;
				vs_cnt         <= 5'h00;
				de_d1          <= 1'b0;
				cur_d1         <= 1'b0;
				hsync          <= 1'b0;
				vsync          <= 1'b0;
				display_enable <= 1'b0;
				cursor         <= 1'b0;
				refresh_addr   <= {ADDR_W{1'b0}};
				raster_line    <= {LINE_W{1'b0}};
			end else if (cc_rise) begin
				hs_cnt <= next_hs_cnt;
				vs_cnt <= next_vs_cnt;
				if (!hend) begin
					hcount <= hcount + 8'h01;
				end else begin
					hcount <= 8'h00;
					if (frame_end) begin
						raster    <= {LINE_W{1'b0}};
						row       <= 7'h00;
						adjusting <= 1'b0;
						row_base  <= start_addr;
						field     <= field + 5'h01;
					end else if (row_end && last_row) begin
						raster    <= {LINE_W{1'b0}};
						adjusting <= 1'b1;
					end else if (row_end) begin
						raster   <= {LINE_W{1'b0}};
						row      <= row + 7'h01;
						row_base <= row_base + {6'h00, hdisp};
					end else begin
						raster <= raster + 5'h01;
					end
				end
				de_d1          <= disp_now;
				cur_d1         <= cur_now;
				display_enable <= mode_control_reg[`CRT_MODE_DE_DELAY] ? de_d1 : disp_now;
				cursor         <= mode_control_reg[`CRT_MODE_CUR_DELAY] ? cur_d1 : cur_now;
				hsync          <= (next_hs_cnt != 5'h00);
				vsync          <= (next_vs_cnt != 5'h00);
				refresh_addr   <= ma_now;
				raster_line    <= raster;
			end
		end
	end
endmodule // crt_raster_timing_controller

// [src/crt_regs.vh]
// Register indices, field positions, reset values and timing counts of the raster timing controller
`ifndef CRT_REGS_VH
`define CRT_REGS_VH

// Internal register numbers held by the index pointer
`define CRT_IDX_HTOTAL      5'h00
`define CRT_IDX_HDISP       5'h01
`define CRT_IDX_HSYNC_POS   5'h02
`define CRT_IDX_SYNC_WIDTH  5'h03
`define CRT_IDX_VTOTAL      5'h04
`define CRT_IDX_VADJUST     5'h05
`define CRT_IDX_VDISP       5'h06
`define CRT_IDX_VSYNC_POS   5'h07
`define CRT_IDX_MODE        5'h08
`define CRT_IDX_ROW_LINES   5'h09
`define CRT_IDX_CARET_START 5'h0A
`define CRT_IDX_CARET_END   5'h0B
`define CRT_IDX_START_HI    5'h0C
`define CRT_IDX_START_LO    5'h0D
`define CRT_IDX_CARET_HI    5'h0E
`define CRT_IDX_CARET_LO    5'h0F
`define CRT_IDX_PEN_HI      5'h10
`define CRT_IDX_PEN_LO      5'h11

// Mode control bit positions
`define CRT_MODE_ROWCOL     2
`define CRT_MODE_DE_DELAY   4
`define CRT_MODE_CUR_DELAY  5

// Status register bit positions
`define CRT_STAT_PEN_FULL   6
`define CRT_STAT_VBLANK     5

// Caret blink mode field and codes
`define CRT_CARET_MODE_HI   6
`define CRT_CARET_MODE_LO   5
`define CRT_CARET_STEADY    2'h0
`define CRT_CARET_OFF       2'h1
`define CRT_CARET_BLINK16   2'h2
`define CRT_CARET_BLINK32   2'h3

// Field counter bits that toggle at 1/16 and 1/32 field rate
`define CRT_BLINK16_BIT     3
`define CRT_BLINK32_BIT     4

// Reset values
`define CRT_RESET_BYTE      8'h00
`define CRT_RESET_ADDR      14'h0000

// Sync width of zero stands for sixteen
`define CRT_SYNC_WIDTH_ZERO 5'h10

// Synchroniser depth in flip-flops
`define CRT_SYNC_STAGES     2

`endif

// [src/crt_sync.v]
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module crt_sync #(
	parameter WIDTH = 1
) (
	input  wire             clock,
	input  wire             rst,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg stage1;
			reg stage2;
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else begin
					stage1 <= async_in[i];
					stage2 <= stage1;
				end
			end
			assign sync_out[i] = stage2;
		end
	endgenerate
endmodule // crt_sync

// [tb/crt_cpu_model.sv]
// Processor bus model driving the register port
`timescale 1ns/1ps
module crt_cpu_model (
	input  wire       clock,
	input  wire [7:0] data_out,
	input  wire       data_oe,
	output logic      bus_phase,
	output logic      select_n,
	output logic      register_select,
	output logic      read_write,
	output wire [7:0] data_in
);
	logic       drv = 1'b0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] last = 8'h00;
	// Undriven lines show a changing pattern
	assign data_in = data_oe ? data_out : drv ? wdat : ~last;
	always @(posedge clock) last <= data_in;
	initial begin
		bus_phase = 1'b0;
		select_n = 1'b1;
		register_select = 1'b0;
		read_write = 1'b1;
	end
	task automatic access(input logic sn, input logic rs, input logic rw, input logic [7:0] wd,
		output logic [7:0] rd);
		@(negedge clock);
		select_n = sn;
		register_select = rs;
		read_write = rw;
		drv = !rw;
		wdat = wd;
		bus_phase = 1'b1;
		repeat (6) @(posedge clock);
		rd = data_in;
		@(negedge clock);
		bus_phase = 1'b0;
		repeat (4) @(negedge clock);
		select_n = 1'b1;
		drv = 1'b0;
		read_write = 1'b1;
	endtask
endmodule // crt_cpu_model

// [tb/crt_monitor.sv]
// Checker of data drive and scan output timing
`timescale 1ns/1ps
module crt_monitor #(
	parameter ADDR_W = 14,
	parameter LINE_W = 5
) (
	input wire              clock,
	input wire              rst,
	input wire              bus_phase,
	input wire              select_n,
	input wire              read_write,
	input wire              data_oe,
	input wire              char_clock,
	input wire              scan_reset_n,
	input wire              hsync,
	input wire              vsync,
	input wire              display_enable,
	input wire              cursor,
	input wire [ADDR_W-1:0] refresh_addr,
	input wire [LINE_W-1:0] raster_line
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_quiet;
		(scan_reset_n && $stable(char_clock)) [*5];
	endsequence
	sequence s_held;
		!scan_reset_n [*4];
	endsequence
	a_oe_on_read: assert property (
		(!select_n && read_write && bus_phase) [*5] |-> data_oe) else $error("No drive on read");
	a_oe_off_idle: assert property (
		select_n [*4] |-> !data_oe) else $error("Drive while not selected");
	a_oe_off_write: assert property (
		!read_write [*4] |-> !data_oe) else $error("Drive during write");
	a_oe_needs_phase: assert property (
		data_oe |-> $past(bus_phase) || $past(bus_phase, 2) || $past(bus_phase, 3) || $past(bus_phase, 4))
		else $error("Drive without phase");
	a_oe_drops: assert property (
		$rose(select_n) |-> ##[1:4] !data_oe) else $error("Drive held after deselect");
	a_scan_held: assert property (
		s_held |-> !hsync && !vsync && !display_enable && !cursor && refresh_addr == 0 && raster_line == 0)
		else $error("Scan outputs active in scan reset");
	a_addr_steady: assert property (
		s_quiet |=> $stable(refresh_addr) && $stable(raster_line)) else $error("Address moved without char edge");
	a_sync_steady: assert property (
		s_quiet |=> $stable(hsync) && $stable(vsync) && $stable(display_enable) && $stable(cursor))
		else $error("Video output moved without char edge");
endmodule // crt_monitor

bind crt_raster_timing_controller crt_monitor #(.ADDR_W(ADDR_W), .LINE_W(LINE_W)) crt_monitor_i (
	.clock(clock), .rst(rst), .bus_phase(bus_phase), .select_n(select_n), .read_write(read_write),
	.data_oe(data_oe), .char_clock(char_clock), .scan_reset_n(scan_reset_n), .hsync(hsync), .vsync(vsync),
	.display_enable(display_enable), .cursor(cursor), .refresh_addr(refresh_addr), .raster_line(raster_line));

// [tb/tb.sv]
// Self-checking bench of the raster timing controller
`timescale 1ns/1ps
`include "crt_regs.vh"
module tb;
	localparam HT = 3, HD = 2, HP = 2, HW = 1, VT = 2, VD = 1, VP = 1, VW = 2, RL = 1;
	logic        clock, rst, char_clock, pen_strobe, scan_reset_n;
	wire         bus_phase, select_n, register_select, read_write, data_oe, hsync, vsync, display_enable, cursor;
	wire  [7:0]  data_in, data_out;
	wire  [13:0] refresh_addr;
	wire  [4:0]  raster_line;
	integer      err_total, check_count, seed, h, ra, row, n, m, era;
	logic [13:0] st, ca, pen_exp, ea;
	logic [7:0]  d;
	logic        pde, pcu, ede, ecu, ehs, evs, coff;
	crt_raster_timing_controller crt_raster_timing_controller_i (.clock(clock), .rst(rst), .bus_phase(bus_phase),
		.select_n(select_n), .register_select(register_select), .read_write(read_write), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .char_clock(char_clock), .pen_strobe(pen_strobe),
		.scan_reset_n(scan_reset_n), .hsync(hsync), .vsync(vsync), .display_enable(display_enable),
		.cursor(cursor), .refresh_addr(refresh_addr), .raster_line(raster_line));
	crt_cpu_model crt_cpu_model_i (.clock(clock), .data_out(data_out), .data_oe(data_oe), .bus_phase(bus_phase),
		.select_n(select_n), .register_select(register_select), .read_write(read_write), .data_in(data_in));
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	initial begin
		char_clock = 0;
		#3;
		forever #80 char_clock = ~char_clock;
	end
	task chk(input string nm, input logic [13:0] e, input logic [13:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [4:0] i, input logic [7:0] v);
		crt_cpu_model_i.access(1'b0, 1'b0, 1'b0, {3'h0, i}, d);
		crt_cpu_model_i.access(1'b0, 1'b1, 1'b0, v, d);
	endtask
	task rd(input logic [4:0] i, output logic [7:0] v);
		crt_cpu_model_i.access(1'b0, 1'b0, 1'b0, {3'h0, i}, d);
		crt_cpu_model_i.access(1'b0, 1'b1, 1'b1, 8'h00, v);
	endtask
	function automatic logic [13:0] f_addr(integer hh, integer rr);
		if (m[`CRT_MODE_ROWCOL])
			f_addr = {st[13:8] + rr[5:0], st[7:0] + hh[7:0]};
		else
			f_addr = 14'(st + rr * HD + hh);
	endfunction
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task run_mode(input integer mm);
		@(negedge clock) scan_reset_n = 0;
		repeat (24) @(negedge clock);
		chk("held", 14'h0000, refresh_addr | {hsync, vsync, display_enable, cursor, raster_line});
		wr(`CRT_IDX_MODE, mm[7:0]);
		m = mm;
		h = 0;
		ra = 0;
		row = 0;
		pde = 0;
		pcu = 0;
		@(negedge char_clock);
		@(negedge clock) scan_reset_n = 1;
		for (n = 0; n < 30; n++) begin
			@(posedge char_clock);
			ea = f_addr(h, row);
			ede = h < HD && row < VD;
			ecu = ede && ea == ca && ra == 0 && !coff;
			ehs = h >= HP && h < HP + HW;
			evs = row >= VP && (row - VP) * (RL + 1) + ra < VW;
			era = ra;
			h++;
			if (h > HT) begin
				h = 0;
				ra++;
			end
			if (ra > RL) begin
				ra = 0;
				row++;
			end
			if (row > VT)
				row = 0;
			if (mm == 0 && n == 9) begin
				@(negedge clock) pen_strobe = 1;
				pen_exp = f_addr(h, row);
			end
			@(negedge char_clock);
			@(negedge clock);
			if (n == 12)
				pen_strobe = 0;
			chk("hsync", ehs, hsync);
			chk("vsync", evs, vsync);
			chk("addr", ea, refresh_addr);
			chk("line", era, raster_line);
			chk("de", mm[4] ? pde : ede, display_enable);
			chk("cursor", mm[5] ? pcu : ecu, cursor);
			pde = ede;
			pcu = ecu;
		end
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		err_total++;
		end_of_test;
	end
	initial begin
		err_total = 0;
		check_count = 0;
		seed = 32'hF618E4EF;
		rst = 1;
		pen_strobe = 0;
		coff = 0;
		scan_reset_n = 0;
		repeat (8) @(posedge clock);
		@(negedge clock) rst = 0;
		repeat (4) @(negedge clock);
		st = {6'h01, 1'b0, 7'($random(seed))};
		ca = st + 14'h0001;
		wr(`CRT_IDX_HTOTAL, HT);
		wr(`CRT_IDX_HDISP, HD);
		wr(`CRT_IDX_HSYNC_POS, HP);
		wr(`CRT_IDX_SYNC_WIDTH, 8'h21);
		wr(`CRT_IDX_VTOTAL, VT);
		wr(`CRT_IDX_VDISP, VD);
		wr(`CRT_IDX_VSYNC_POS, VP);
		wr(`CRT_IDX_ROW_LINES, RL);
		wr(`CRT_IDX_START_HI, {2'h0, st[13:8]});
		wr(`CRT_IDX_START_LO, st[7:0]);
		wr(`CRT_IDX_CARET_HI, {2'h0, ca[13:8]});
		wr(`CRT_IDX_CARET_LO, ca[7:0]);
		run_mode(8'h00);
		crt_cpu_model_i.access(1'b0, 1'b0, 1'b1, 8'h00, d);
		chk("pen_flag", 14'h0040, d & 8'h40);
		rd(`CRT_IDX_PEN_HI, d);
		chk("pen_hi", pen_exp[13:8], d);
		rd(`CRT_IDX_PEN_LO, d);
		chk("pen_lo", pen_exp[7:0], d);
		crt_cpu_model_i.access(1'b0, 1'b0, 1'b1, 8'h00, d);
		chk("pen_clear", 14'h0000, d & 8'h40);
		rd(`CRT_IDX_HTOTAL, d);
		chk("write_only", 14'h0000, d);
		wr(`CRT_IDX_PEN_HI, 8'hFF);
		rd(`CRT_IDX_PEN_HI, d);
		chk("pen_keep", pen_exp[13:8], d);
		crt_cpu_model_i.access(1'b0, 1'b0, 1'b0, 8'hEF, d);
		crt_cpu_model_i.access(1'b1, 1'b0, 1'b0, 8'h00, d);
		crt_cpu_model_i.access(1'b1, 1'b1, 1'b1, 8'h00, d);
		crt_cpu_model_i.access(1'b0, 1'b1, 1'b1, 8'h00, d);
		chk("indexed", ca[7:0], d);
		wr(`CRT_IDX_CARET_START, 8'h20);
		coff = 1;
		run_mode(8'h04);
		wr(`CRT_IDX_CARET_START, 8'h00);
		coff = 0;
		run_mode(8'h30);
		end_of_test;
	end
endmodule // tb
